// ===== logic/bus_slave_top.v
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "bus_slave_map.vh"
// Functional notes
// - Status bit0 follows ninth-clock acknowledge level in transmit mode only
// - Status bit2 set on read, cleared write
// - Status bit5 high while bus busy
// - START is SDA falling while SCL high
// - Match sets matched flag, interrupt, done
// - Done flag low shifting, high after byte
// - Compare first seven bits with own address
// - Store eighth bit, acknowledge on ninth
// - Hold SCL low until data register serviced
// - One interrupt for match and byte done
// - Software sets transmit mode from direction
// - Bytes eight bits, most significant first
// - Receiver ninth bit from acknowledge select
// - Transmitter releases SDA on missing acknowledge
// - Software loads or reads data each byte
// - On nack, receive mode and dummy read
// - Control bits: ack select, transmit, enable
// - Control write clears matched flag
// - STOP clears bus busy flag
// - Interrupt vectors to location 10H
module bus_slave_top (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sclIn,
    output reg sclOut,
    output reg sclOe_n,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe_n,
    output reg busIrq,
    output reg [7:0] irqVector
);
    // ****************************************
    // States
    // ****************************************
    localparam IDLE = 3'd0;
    localparam ADDR = 3'd1;
    localparam ACKA = 3'd2;
    localparam HOLD = 3'd3;
    localparam XFER = 3'd4;
    localparam ACKD = 3'd5;
    localparam SKIP = 3'd6;

    // ****************************************
    // Pin sampling and APB decode
    // ****************************************
    wire scl;
    wire sclRise;
    wire sclFall;
    wire sda;
    wire sdaRise;
    wire sdaFall;
    wire aReady;
    wire aErr;
    wire wrCtrlAcc;
    wire wrAddrAcc;
    wire wrDataAcc;
    wire rdDataAcc;
    wire rdStat;
    wire rdCtrl;
    wire rdAddr;
    wire rdIrq;

    pin_sync sclSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(sclIn),
        .level(scl),
        .rise(sclRise),
        .fall(sclFall)
    );
    pin_sync sdaSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(sdaIn),
        .level(sda),
        .rise(sdaRise),
        .fall(sdaFall)
    );
    apb_regs regs (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(aReady),
        .pslverr(aErr),
        .wrCtrl(wrCtrlAcc),
        .wrAddr(wrAddrAcc),
        .wrData(wrDataAcc),
        .rdData(rdDataAcc),
        .rdStat(rdStat),
        .rdCtrl(rdCtrl),
        .rdAddr(rdAddr),
        .rdIrq(rdIrq)
    );
    // Side effects land once, at the edge that completes the access
    wire wrCtrl = wrCtrlAcc & pready;
    wire wrAddr = wrAddrAcc & pready;
    wire wrData = wrDataAcc & pready;
    wire rdData = rdDataAcc & pready;

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] ctrl_reg;
    reg [7:0] ownAddr_reg;
    reg [7:0] txData_reg;
    reg [7:0] rxData_reg;
    reg [7:0] shift_reg;
    reg [3:0] bitCnt_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg peerNack_reg;
    reg readReq_reg;
    reg busy_reg;
    reg matched_reg;
    reg done_reg;
    reg irqPend_reg;
    reg sdaLow_reg;
    reg sclLow_reg;

    wire enabled = ctrl_reg[`CTRL_EN_BIT];
    wire txMode = ctrl_reg[`CTRL_TX_BIT];
    wire startSeen = sdaFall & scl;
    wire stopSeen = sdaRise & scl;
    wire serviced = wrData | rdData;
    wire addrHit = shift_reg[7:1] == ownAddr_reg[7:1];

    function [7:0] statusByte;
        input nack;
        input rw;
        input busy;
        input match;
        input done;
        begin
            statusByte = {done, match, busy, 2'b00, rw, 1'b0, nack};
        end
    endfunction

    // ****************************************
    // Transfer state machine
    // ****************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            IDLE: state_next = IDLE;
            ADDR: if (sclFall && bitCnt_reg == 4'd8) begin
                state_next = addrHit ? ACKA : SKIP;
            end
            ACKA: if (sclFall) begin
                state_next = HOLD;
            end
            HOLD: if (serviced) begin
                state_next = XFER;
            end
            XFER: if (sclFall && bitCnt_reg == 4'd8) begin
                state_next = ACKD;
            end
            ACKD: if (sclFall) begin
                state_next = (txMode && peerNack_reg) ? SKIP : HOLD;
            end
            SKIP: state_next = SKIP;
            default: state_next = IDLE;
        endcase
        if (!enabled || stopSeen) begin
            state_next = IDLE;
        end
        if (enabled && startSeen) begin
            state_next = ADDR;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= IDLE;
            bitCnt_reg <= 4'd0;
            shift_reg <= 8'h00;
            rxData_reg <= 8'h00;
            peerNack_reg <= 1'b0;
            readReq_reg <= 1'b0;
            done_reg <= 1'b1;
            matched_reg <= 1'b0;
            irqPend_reg <= 1'b0;
            sdaLow_reg <= 1'b0;
            sclLow_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            irqPend_reg <= 1'b0;
            if (wrCtrl) begin
                matched_reg <= 1'b0;
            end
            if (startSeen) begin
                bitCnt_reg <= 4'd0;
            end
            case (state_reg)
                ADDR: begin
                    if (sclRise) begin
                        shift_reg <= {shift_reg[6:0], sda};
                        bitCnt_reg <= bitCnt_reg + 4'd1;
                    end
                    if (sclFall && bitCnt_reg == 4'd8 && addrHit) begin
                        readReq_reg <= shift_reg[0];
                        sdaLow_reg <= 1'b1;
                        matched_reg <= 1'b1;
                        done_reg <= 1'b1;
                        irqPend_reg <= 1'b1;
                    end
                end
                ACKA: if (sclFall) begin
                    sdaLow_reg <= 1'b0;
                    sclLow_reg <= 1'b1;
                end
                HOLD: if (serviced) begin
                    bitCnt_reg <= 4'd0;
                    done_reg <= 1'b0;
                    shift_reg <= txData_reg;
                    if (wrData) begin
                        shift_reg <= pwdata[7:0];
                    end
                    sdaLow_reg <= txMode & ~(wrData ? pwdata[7] : txData_reg[7]);
                end
                XFER: begin
                    // SCL let go a cycle after the first bit, so no false START
                    sclLow_reg <= 1'b0;
                    if (sclRise) begin
                        bitCnt_reg <= bitCnt_reg + 4'd1;
                        if (!txMode) begin
                            shift_reg <= {shift_reg[6:0], sda};
                        end
                    end
                    if (sclFall && txMode && bitCnt_reg != 4'd8) begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sdaLow_reg <= ~shift_reg[6];
                    end
                    if (sclFall && bitCnt_reg == 4'd8) begin
                        done_reg <= 1'b1;
                        irqPend_reg <= 1'b1;
                        // Receiver drives ack select, transmitter releases for peer
                        sdaLow_reg <= ~txMode & ~ctrl_reg[`CTRL_ACK_BIT];
                        if (!txMode) begin
                            rxData_reg <= shift_reg;
                        end
                    end
                end
                ACKD: begin
                    if (sclRise && txMode) begin
                        peerNack_reg <= sda;
                    end
                    if (sclFall) begin
                        sdaLow_reg <= 1'b0;
                        sclLow_reg <= ~(txMode & peerNack_reg);
                    end
                end
                default: begin
                    sdaLow_reg <= 1'b0;
                    sclLow_reg <= 1'b0;
                end
            endcase
            if (state_next == IDLE || state_next == ADDR) begin
                sdaLow_reg <= 1'b0;
                sclLow_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Bus busy flag
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else if (startSeen) begin
            busy_reg <= 1'b1;
        end else if (stopSeen) begin
            busy_reg <= 1'b0;
        end
    end

    // ****************************************
    // Software registers and outputs
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RESET;
            ownAddr_reg <= `OWN_ADDR_RESET;
            txData_reg <= 8'h00;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            sclOut <= 1'b0;
            sclOe_n <= 1'b1;
            sdaOut <= 1'b0;
            sdaOe_n <= 1'b1;
            busIrq <= 1'b0;
            irqVector <= `IRQ_VECTOR;
        end else begin
            if (wrCtrl) begin
                ctrl_reg <= pwdata[7:0] & `CTRL_MASK;
            end
            if (wrAddr) begin
                ownAddr_reg <= {pwdata[7:1], 1'b0};
            end
            if (wrData) begin
                txData_reg <= pwdata[7:0];
            end
            // Registered answer: access phase lasts two cycles
            pready <= psel & penable & ~pready & aReady;
            pslverr <= psel & penable & ~pready & aErr;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                if (rdStat) begin
                    prdata <= {24'h000000, statusByte(peerNack_reg, readReq_reg, busy_reg,
                        matched_reg, done_reg)};
                end else if (rdCtrl) begin
                    prdata <= {24'h000000, ctrl_reg};
                end else if (rdAddr) begin
                    prdata <= {24'h000000, ownAddr_reg};
                end else if (!pwrite && paddr == `DATA_ADDR) begin
                    prdata <= {24'h000000, rxData_reg};
                end else if (rdIrq) begin
                    prdata <= {24'h000000, `IRQ_VECTOR};
                end
            end else if (psel && penable && !pready) begin
                prdata <= prdata;
            end
            busIrq <= irqPend_reg;
            irqVector <= `IRQ_VECTOR;
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            sdaOe_n <= ~sdaLow_reg;
            sclOe_n <= ~sclLow_reg;
        end
    end
endmodule // bus_slave_top

// ===== common/bus_slave_map.vh
`ifndef BUS_SLAVE_MAP_VH
`define BUS_SLAVE_MAP_VH
// Register indexes (printed offsets) and byte addresses
`define OWN_ADDR_IDX 8'h20
`define CTRL_IDX 8'h21
`define STAT_IDX 8'h22
`define DATA_IDX 8'h23
`define IRQ_IDX 8'h24
`define OWN_ADDR_ADDR 12'h080
`define CTRL_ADDR 12'h084
`define STAT_ADDR 12'h088
`define DATA_ADDR 12'h08c
`define IRQ_ADDR 12'h090
// Control fields
`define CTRL_ACK_BIT 3
`define CTRL_TX_BIT 4
`define CTRL_EN_BIT 7
`define CTRL_MASK 8'h98
// Status fields
`define STAT_NACK_BIT 0
`define STAT_RW_BIT 2
`define STAT_BUSY_BIT 5
`define STAT_MATCH_BIT 6
`define STAT_DONE_BIT 7
// Reset values
`define CTRL_RESET 8'h00
`define OWN_ADDR_RESET 8'h00
// Interrupt vector location
`define IRQ_VECTOR 8'h10
`endif

// ===== logic/pin_sync.v
`timescale 1ns/1ps
// ****************************************
// Two-flop synchroniser with edge detect
// ****************************************
module pin_sync (
    input wire ref_clk,
    input wire rst,
    input wire pinIn,
    output reg level,
    output wire rise,
    output wire fall
);
    reg meta_reg;
    reg prev_reg;
    always @(posedge ref_clk) begin
        if (rst) begin
            meta_reg <= 1'b1;
            level <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pinIn;
            level <= meta_reg;
            prev_reg <= level;
        end
    end
    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;
endmodule // pin_sync

// ===== logic/apb_regs.v
`timescale 1ns/1ps
`include "bus_slave_map.vh"
// ****************************************
// APB slave decode; pready tied high here, the top adds one wait state
// ****************************************
module apb_regs (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    output wire pready,
    output wire pslverr,
    output wire wrCtrl,
    output wire wrAddr,
    output wire wrData,
    output wire rdData,
    output wire rdStat,
    output wire rdCtrl,
    output wire rdAddr,
    output wire rdIrq
);
    wire acc = psel & penable;
    wire hit = (paddr == `OWN_ADDR_ADDR) | (paddr == `CTRL_ADDR) | (paddr == `STAT_ADDR)
        | (paddr == `DATA_ADDR) | (paddr == `IRQ_ADDR);
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign wrCtrl = acc & pwrite & (paddr == `CTRL_ADDR);
    assign wrAddr = acc & pwrite & (paddr == `OWN_ADDR_ADDR);
    assign wrData = acc & pwrite & (paddr == `DATA_ADDR);
    assign rdData = acc & ~pwrite & (paddr == `DATA_ADDR);
    assign rdStat = ~pwrite & (paddr == `STAT_ADDR);
    assign rdCtrl = ~pwrite & (paddr == `CTRL_ADDR);
    assign rdAddr = ~pwrite & (paddr == `OWN_ADDR_ADDR);
    assign rdIrq = ~pwrite & (paddr == `IRQ_ADDR);
endmodule // apb_regs

// ===== tb/bus_slave_top_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port checks for the bus slave
// ****************************************
module bus_slave_top_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclOut,
    input wire logic sdaOut,
    input wire logic busIrq,
    input wire logic [7:0] irqVector,
    input wire logic sclIn,
    input wire logic sdaOe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_vector_fixed: assert property (irqVector == 8'h10)
        else $error("vector not fixed");
    a_vector_read: assert property (
        pready && !pwrite && paddr == 12'h090 |-> prdata == 32'h10)
        else $error("vector read wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_latency: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    a_err_unmapped: assert property (
        pready |-> pslverr == !(paddr inside {12'h080, 12'h084, 12'h088, 12'h08c, 12'h090}))
        else $error("pslverr wrong");
    a_err_needs_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_irq_pulse: assert property (busIrq |=> !busIrq)
        else $error("irq too long");
    a_sda_open_drain: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
    a_scl_open_drain: assert property (sclOut == 1'b0)
        else $error("scl driven high");
    a_sda_scl_low: assert property ($changed(sdaOe_n) |-> !sclIn)
        else $error("sda moved while scl high");
endmodule // bus_slave_top_sva
bind bus_slave_top bus_slave_top_sva chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclOut(sclOut), .sdaOut(sdaOut), .busIrq(busIrq), .irqVector(irqVector),
    .sclIn(sclIn), .sdaOe_n(sdaOe_n));

// ===== tb/i2c_master_model.sv
`timescale 1ns/1ps
// ****************************************
// Two-wire bus master, 64 ns bit period
// ****************************************
module i2c_master_model (
    input wire ref_clk,
    input wire sclLine,
    input wire sdaLine,
    output reg sclM,
    output reg sdaM
);
    initial begin
        sclM = 1'b1;
        sdaM = 1'b1;
    end
    // Releases clock and waits out any stretch
    task waitHigh;
        begin
            sclM = 1'b1;
            while (sclLine !== 1'b1) begin
                #8;
            end
        end
    endtask
    // Pin moves stay on falling clock edges, away from the sampling edge
    task startCond;
        begin
            @(negedge ref_clk);
            sdaM = 1'b1;
            waitHigh;
            #32 sdaM = 1'b0;
            #32 sclM = 1'b0;
        end
    endtask
    task stopCond;
        begin
            @(negedge ref_clk);
            sclM = 1'b0;
            sdaM = 1'b0;
            #32 waitHigh;
            #32 sdaM = 1'b1;
            #32;
        end
    endtask
    task xfer(input [7:0] d, input ackIn, output [7:0] q, output ack);
        integer i;
        reg [8:0] s;
        begin
            @(negedge ref_clk);
            // Long low phase leaves the slave time to move SDA before SCL rises
            for (i = 8; i >= 0; i = i - 1) begin
                sdaM = (i == 0) ? ackIn : d[i-1];
                #40 waitHigh;
                #12 s[i] = sdaLine;
                #12 sclM = 1'b0;
            end
            q = s[8:1];
            ack = s[0];
        end
    endtask
endmodule // i2c_master_model

// ===== tb/bus_slave_top_tb.sv
`timescale 1ns/1ps
`include "bus_slave_map.vh"
`define CHK(nm, ex, got) begin \
    total_checks = total_checks + 1; \
    if ((got) !== (ex)) begin \
        n_errors = n_errors + 1; \
        $display("FAIL %s expected %h seen %h", nm, ex, got); \
    end \
end
module bus_slave_top_tb;
    reg ref_clk, rst, psel, penable, pwrite;
    reg [11:0] paddr;
    reg [31:0] pwdata, seed, rd;
    reg err, ack;
    reg [6:0] own;
    reg [7:0] d1, d2, q;
    wire [31:0] prdata;
    wire [7:0] irqVector;
    wire pready, pslverr, sclOut, sclOe_n, sdaOut, sdaOe_n, busIrq, sclM, sdaM, sclLine, sdaLine;
    integer n_errors, total_checks, cycles, irqCount, n;
    assign sclLine = sclM & (sclOe_n | sclOut);
    assign sdaLine = sdaM & (sdaOe_n | sdaOut);
    bus_slave_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclIn(sclLine), .sclOut(sclOut), .sclOe_n(sclOe_n),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .busIrq(busIrq),
        .irqVector(irqVector));
    i2c_master_model master (.ref_clk(ref_clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclM(sclM), .sdaM(sdaM));
    // ****************************************
    // Clock, timeout, helpers
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (busIrq === 1'b1) irqCount = irqCount + 1;
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    function [31:0] xorshift(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xorshift = x ^ (x << 5);
        end
    endfunction
    task apb(input wr, input [11:0] a, input [7:0] wd);
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= {24'h0, wd};
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1) begin
                @(posedge ref_clk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task stat;
        begin
            repeat (4) @(posedge ref_clk);
            apb(1'b0, `STAT_ADDR, 8'h00);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        n_errors = 0;
        total_checks = 0;
        cycles = 0;
        irqCount = 0;
        seed = 32'h80a9;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, `CTRL_ADDR, 8'h00);
        `CHK("ctrl reset", 32'h0, rd)
        apb(1'b1, `STAT_ADDR, 8'hff);
        apb(1'b0, `STAT_ADDR, 8'h00);
        `CHK("status reset", 8'h80, rd[7:0])
        apb(1'b0, `IRQ_ADDR, 8'h00);
        `CHK("vector", 32'h10, rd)
        apb(1'b1, 12'h0a0, 8'h55);
        `CHK("unmapped", 1'b1, err)
        seed = xorshift(seed);
        own = seed[7:1] | 7'h08;
        d1 = seed[15:8];
        d2 = seed[23:16];
        apb(1'b1, `OWN_ADDR_ADDR, {own, 1'b0});
        apb(1'b1, `CTRL_ADDR, 8'h80);
        apb(1'b0, `CTRL_ADDR, 8'h00);
        `CHK("ctrl", 32'h80, rd)
        master.startCond;
        master.xfer({own, 1'b0}, 1'b1, q, ack);
        `CHK("addr ack", 1'b0, ack)
        `CHK("irq match", 1, irqCount)
        stat;
        `CHK("stat write", 8'he0, rd[7:0] & 8'he4)
        fork
            master.xfer(d1, 1'b1, q, ack);
            begin
                apb(1'b1, `CTRL_ADDR, 8'h80);
                stat;
                `CHK("match clear", 1'b0, rd[6])
                apb(1'b0, `DATA_ADDR, 8'h00);
            end
        join
        `CHK("rx ack", 1'b0, ack)
        `CHK("irq byte", 2, irqCount)
        apb(1'b0, `DATA_ADDR, 8'h00);
        `CHK("rx data", {24'h0, d1}, rd)
        fork
            master.xfer(d2, 1'b1, q, ack);
            apb(1'b1, `CTRL_ADDR, 8'h88);
        join
        `CHK("rx nack", 1'b1, ack)
        apb(1'b0, `DATA_ADDR, 8'h00);
        `CHK("rx data2", {24'h0, d2}, rd)
        apb(1'b1, `CTRL_ADDR, 8'h80);
        master.stopCond;
        stat;
        `CHK("busy clear", 1'b0, rd[5])
        master.startCond;
        master.xfer({own, 1'b1}, 1'b1, q, ack);
        stat;
        `CHK("stat read", 8'he4, rd[7:0] & 8'he4)
        fork
            master.xfer(8'hff, 1'b0, q, ack);
            begin
                apb(1'b1, `CTRL_ADDR, 8'h90);
                apb(1'b1, `DATA_ADDR, d1);
                repeat (40) @(posedge ref_clk);
                stat;
                `CHK("done shifting", 1'b0, rd[7])
            end
        join
        `CHK("tx data", d1, q)
        stat;
        `CHK("peer ack", 1'b0, rd[0])
        fork
            master.xfer(8'hff, 1'b1, q, ack);
            apb(1'b1, `DATA_ADDR, d2);
        join
        `CHK("tx data2", d2, q)
        stat;
        `CHK("peer nack", 1'b1, rd[0])
        apb(1'b1, `CTRL_ADDR, 8'h80);
        apb(1'b0, `DATA_ADDR, 8'h00);
        `CHK("sda released", 1'b1, sdaOe_n)
        master.stopCond;
        n = irqCount;
        master.startCond;
        master.xfer({own ^ 7'h01, 1'b0}, 1'b1, q, ack);
        `CHK("no ack", 1'b1, ack)
        `CHK("scl free", 1'b1, sclOe_n)
        master.stopCond;
        `CHK("no irq", n, irqCount)
        // Disabled block ignores even its own address
        apb(1'b1, `CTRL_ADDR, 8'h00);
        master.startCond;
        master.xfer({own, 1'b0}, 1'b1, q, ack);
        `CHK("disabled ack", 1'b1, ack)
        master.stopCond;
        `CHK("disabled irq", n, irqCount)
        final_report;
    end
endmodule // bus_slave_top_tb
